// ### design/scml_mode_latches.sv
/*
  Per-channel mode latch bank of a four-channel serial transceiver: decoder
  variant and enable, receive output clock source and rate, detector
  thresholds and encoder enable, with the clock scheme decode per channel.
  Assumes a 25 MHz clk_i, synchronous strobes from software, and that the
  reference clock rate of each channel is a static strap input.
*/
// The address map and strobed register access were chosen for this implementation.
// Notes on behaviour
// - Decode variant resets 1; 1 primary mode
// - Variant picks special-character decode column
// - Decoder enable resets 1; 0 passes raw
// - Clock source resets 1; 1 reference clock
// - Half-rate select resets 1, sets clock rate
// - Half, recovered source: recovered at half rate
// - Full, recovered source: recovered at full rate
// - Half, reference full-rate: reference half rate
// - Full, reference full-rate: reference full rate
// - Reference half-rate ignores rate, gives half
// - Primary threshold two bits, resets 10
// - Secondary threshold two bits, resets 10
// - Encoder enable resets 1; 0 sends raw
`include "scml_map.svh"

module scml_mode_latches #(
  parameter int NCH = 4
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [NCH-1:0] ref_half_rate_i,
  output logic [31:0] rdata_o,
  output logic [NCH-1:0] rx_decode_variant_sel_o,
  output logic [NCH-1:0] rx_decoder_enable_o,
  output logic [NCH-1:0] rx_out_clock_source_sel_o,
  output logic [NCH-1:0] rx_out_clock_half_rate_sel_o,
  output logic [NCH*2-1:0] primary_detect_threshold_sel_o,
  output logic [NCH*2-1:0] secondary_detect_threshold_sel_o,
  output logic [NCH-1:0] tx_encoder_enable_o,
  output logic [NCH-1:0] rx_special_col_o,
  output logic [NCH-1:0] rx_clk_from_ref_o,
  output logic [NCH-1:0] rx_clk_half_o,
  output logic [NCH-1:0] primary_detect_on_o,
  output logic [NCH-1:0] secondary_detect_on_o
);
  localparam int W = `SCML_CH_BITS;

  // Elaboration check: the address map and strap echo serve four channels
  if (NCH != 4) begin : g_nch_check
    $error("scml_mode_latches serves exactly four channels");
  end

  // ***********************************************************************
  // Address decode
  // ***********************************************************************
  function automatic logic is_ch(input logic [7:0] a);
    return a[7:4] == 4'h0 && a[1:0] == 2'b00;
  endfunction

  wire logic wr_hit = wr_i && is_ch(addr_i);
  wire logic [1:0] ch_idx = addr_i[3:2];
  wire logic [W-1:0] wr_word = wdata_i[W-1:0];
  wire logic [NCH*W-1:0] all_words;
  wire logic [W-1:0] mem_rdata;

  // Channel words live in the small store; writes hit one channel only
  scml_latch_mem #(
    .NCH(NCH),
    .W(W)
  ) u_mem (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .we_i(wr_hit),
    .widx_i(ch_idx),
    .wdata_i(wr_word),
    .ridx_i(ch_idx),
    .rdata_o(mem_rdata),
    .all_o(all_words)
  );

  // ***********************************************************************
  // Read path: source chosen in the strobe cycle
  // ***********************************************************************
  // The answer must stand in the very next cycle and leave a flip-flop, so
  // the word is picked from the store outputs here; the registered read
  // port of the store would add a second cycle of latency.
  wire logic rd_ch_now = rd_i && is_ch(addr_i);
  wire logic rd_stat_now = rd_i && addr_i == `SCML_OFS_STAT;
  wire logic rd_strap_now = rd_i && addr_i == `SCML_OFS_STRAP;
  wire logic [W-1:0] sel_word = all_words[ch_idx*W +: W];

  // Channel read seen one cycle ago, kept for the read port cross-check
  logic rd_ch;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rd_ch <= 1'b0;
    end else begin
      rd_ch <= rd_ch_now;
    end
  end

  // ***********************************************************************
  // Per-channel field split and clock scheme decode
  // ***********************************************************************
  logic [NCH-1:0] f_var, f_den, f_src, f_half, f_een;
  logic [NCH*2-1:0] f_pri, f_sec;
  logic [NCH-1:0] n_col, n_ref, n_hlf, n_pon, n_son;
  logic [NCH*2-1:0] scheme;

  for (genvar c = 0; c < NCH; c++) begin : g_dec
    wire logic [W-1:0] w = all_words[c*W +: W];
    assign f_var[c] = w[`SCML_B_DEC_VAR];
    assign f_den[c] = w[`SCML_B_DEC_EN];
    assign f_src[c] = w[`SCML_B_CK_SRC];
    assign f_half[c] = w[`SCML_B_CK_HALF];
    assign f_pri[c*2 +: 2] = w[`SCML_B_PRI_HI:`SCML_B_PRI_LO];
    assign f_sec[c*2 +: 2] = w[`SCML_B_SEC_HI:`SCML_B_SEC_LO];
    assign f_een[c] = w[`SCML_B_ENC_EN];
    // Column choice only matters with the decoder in the path
    assign n_col[c] = f_den[c] & f_var[c];
    assign n_ref[c] = f_src[c];
    // Half-rate reference forces half rate regardless of the rate bit
    assign n_hlf[c] = (f_src[c] & ref_half_rate_i[c]) | f_half[c];
    assign n_pon[c] = f_pri[c*2 +: 2] != scml_pkg::SCML_THR_OFF;
    assign n_son[c] = f_sec[c*2 +: 2] != scml_pkg::SCML_THR_OFF;
    assign scheme[c*2 +: 2] = {n_ref[c], n_hlf[c]};
  end

  // Status word: the clock scheme and detector state of every channel
  wire logic [31:0] stat_word = {16'h0000, n_son, n_pon, scheme};
  wire logic [31:0] strap_word = {28'h0000000, ref_half_rate_i};
  wire logic [31:0] next_rdata = rd_ch_now ? {23'h000000, sel_word} :
                                 rd_stat_now ? stat_word :
                                 rd_strap_now ? strap_word : 32'h00000000;

  // ***********************************************************************
  // Output registers
  // ***********************************************************************
  // Registered outputs trade one cycle of lag for glitch-free controls
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rx_decode_variant_sel_o <= '1;
      rx_decoder_enable_o <= '1;
      rx_out_clock_source_sel_o <= '1;
      rx_out_clock_half_rate_sel_o <= '1;
      primary_detect_threshold_sel_o <= {NCH{`SCML_RST_THR}};
      secondary_detect_threshold_sel_o <= {NCH{`SCML_RST_THR}};
      tx_encoder_enable_o <= '1;
    end else begin
      rx_decode_variant_sel_o <= f_var;
      rx_decoder_enable_o <= f_den;
      rx_out_clock_source_sel_o <= f_src;
      rx_out_clock_half_rate_sel_o <= f_half;
      primary_detect_threshold_sel_o <= f_pri;
      secondary_detect_threshold_sel_o <= f_sec;
      tx_encoder_enable_o <= f_een;
    end
  end

  // Decoded controls for the datapath and the output clock generator
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rx_special_col_o <= '1;
      rx_clk_from_ref_o <= '1;
      rx_clk_half_o <= '1;
      primary_detect_on_o <= '1;
      secondary_detect_on_o <= '1;
    end else begin
      rx_special_col_o <= n_col;
      rx_clk_from_ref_o <= n_ref;
      rx_clk_half_o <= n_hlf;
      primary_detect_on_o <= n_pon;
      secondary_detect_on_o <= n_son;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rdata_o <= 32'h00000000;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // ***********************************************************************
  // Checks
  // ***********************************************************************
  sequence s_wr_ch0(bit [8:0] v);
    wr_i && addr_i == `SCML_OFS_CH0 && wdata_i[8:0] == v;
  endsequence

  // Write of one bit value into one channel word
  sequence s_wr_bit(logic [7:0] a, int b, bit v);
    wr_i && addr_i == a && wdata_i[b] == v;
  endsequence

  // Any write into one channel word
  sequence s_wr_at(logic [7:0] a);
    wr_i && addr_i == a;
  endsequence

  // Store takes the word on the write edge, the outputs one edge later
  sequence s_land;
    ##1 1'b1;
  endsequence

  a_half_ref_forced: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (f_src[2] && ref_half_rate_i[2]) |=> rx_clk_half_o[2])
    else $error("half-rate reference did not force half rate");

  a_rec_full_rate: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!f_src[2] && !f_half[2]) |=> !rx_clk_half_o[2] && !rx_clk_from_ref_o[2])
    else $error("recovered full rate not selected");

  a_rec_half_rate: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!f_src[2] && f_half[2]) |=> rx_clk_half_o[2] && !rx_clk_from_ref_o[2])
    else $error("recovered half rate not selected");

  a_ref_full_rate: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (f_src[2] && !f_half[2] && !ref_half_rate_i[2]) |=> !rx_clk_half_o[2] && rx_clk_from_ref_o[2])
    else $error("reference full rate not selected");

  a_ref_half_rate: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (f_src[0] && f_half[0]) |=> rx_clk_half_o[0] && rx_clk_from_ref_o[0])
    else $error("reference half rate not selected");

  a_bypass_no_col: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !rx_decoder_enable_o[3] |-> !rx_special_col_o[3])
    else $error("column active while decoder bypassed");

  a_col_follows_var: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rx_decoder_enable_o[3] |-> rx_special_col_o[3] == rx_decode_variant_sel_o[3])
    else $error("column does not follow decode variant");

  a_write_isolated: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_wr_ch0(9'h000) |=> ##1 rx_decoder_enable_o[0] == 1'b0
      && rx_decoder_enable_o[1] == $past(rx_decoder_enable_o[1]))
    else $error("channel write not isolated");

  a_reset_values: assert property (@(posedge clk_i)
    $rose(rstn_i) |-> rx_decode_variant_sel_o == '1 && rx_decoder_enable_o == '1
      && tx_encoder_enable_o == '1 && rx_out_clock_source_sel_o == '1
      && rx_out_clock_half_rate_sel_o == '1)
    else $error("single-bit fields not at reset values");

  a_thr_reset: assert property (@(posedge clk_i)
    $rose(rstn_i) |-> primary_detect_threshold_sel_o == 8'hAA
      && secondary_detect_threshold_sel_o == 8'hAA)
    else $error("thresholds not at reset value");

  a_detect_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (f_sec[1:0] == 2'b00) |=> !secondary_detect_on_o[0])
    else $error("secondary detector not disabled");

  a_enc_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_wr_ch0(9'h000) |=> ##1 !tx_encoder_enable_o[0])
    else $error("encoder enable not cleared");

  a_enc_isolated: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_wr_ch0(9'h000) |=> ##1 tx_encoder_enable_o[3:1] == $past(tx_encoder_enable_o[3:1]))
    else $error("encoder write reached another channel");

  a_ref_half_ignores: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (f_src[2] && ref_half_rate_i[2] && !f_half[2]) |=> rx_clk_half_o[2] && rx_clk_from_ref_o[2])
    else $error("rate bit not ignored with half-rate reference");

  a_decoded_reset: assert property (@(posedge clk_i)
    $rose(rstn_i) |-> rx_clk_half_o == '1 && rx_clk_from_ref_o == '1
      && rx_special_col_o == '1)
    else $error("decoded controls not at reset values");

  a_pri_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (f_pri[1:0] == 2'b00) |=> !primary_detect_on_o[0])
    else $error("primary detector not disabled");

  a_pri_on: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (f_pri[7:6] != 2'b00) |=> primary_detect_on_o[3])
    else $error("primary detector not enabled");

  a_sec_on: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (f_sec[7:6] != 2'b00) |=> secondary_detect_on_o[3])
    else $error("secondary detector not enabled");

  // ***********************************************************************
  // Write landing checks
  // ***********************************************************************
  a_src_rec_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_wr_bit(`SCML_OFS_CH2, `SCML_B_CK_SRC, 1'b0) |=> s_land
      ##0 (!rx_out_clock_source_sel_o[2] && !rx_clk_from_ref_o[2]))
    else $error("recovered clock source not applied");

  a_dec_bypass_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_wr_bit(`SCML_OFS_CH3, `SCML_B_DEC_EN, 1'b0) |=> s_land
      ##0 (!rx_decoder_enable_o[3] && !rx_special_col_o[3]))
    else $error("bypassed decoder still selects a column");

  a_pri_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_wr_at(`SCML_OFS_CH3) |=> s_land
      ##0 (primary_detect_threshold_sel_o[7:6] == $past(wdata_i[5:4], 2)))
    else $error("primary threshold not written");

  a_sec_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_wr_at(`SCML_OFS_CH3) |=> s_land
      ##0 (secondary_detect_threshold_sel_o[7:6] == $past(wdata_i[7:6], 2)))
    else $error("secondary threshold not written");

  // A write elsewhere must leave the encoder enable, decoder enable and primary threshold of every other channel untouched
  for (genvar c = 0; c < NCH; c++) begin : g_iso
    a_other_write_kept: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (wr_i && addr_i[3:2] != 2'(c)) |=> ##1 $stable(tx_encoder_enable_o[c])
        && $stable(rx_decoder_enable_o[c])
        && $stable(primary_detect_threshold_sel_o[c*2 +: 2]))
      else $error("write changed a channel it did not address");
  end

  // ***********************************************************************
  // Bus read checks
  // ***********************************************************************
  // The read port of the store must agree with the word sent out
  a_read_port: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_ch |-> rdata_o[W-1:0] == mem_rdata)
    else $error("read data disagree with the store read port");

  a_ch_read_upper: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (rd_i && is_ch(addr_i)) |=> rdata_o[31:W] == '0)
    else $error("unused channel word bits not zero");

  a_stat_read_upper: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (rd_i && addr_i == `SCML_OFS_STAT) |=> rdata_o[31:16] == 16'h0000)
    else $error("unused status bits not zero");

  a_unmapped_read: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (rd_i && !is_ch(addr_i) && addr_i != `SCML_OFS_STAT && addr_i != `SCML_OFS_STRAP)
      |=> rdata_o == 32'h00000000)
    else $error("unmapped read did not return zero");

  // Read data stand one cycle only; idle cycles read as zero
  a_rdata_idle: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !rd_i |=> rdata_o == 32'h00000000)
    else $error("read data stand outside the answer cycle");
endmodule

// ### design/scml_map.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  per-channel mode latch bank.
  Assumes it is included by bare name from the design files.
*/
`ifndef SCML_MAP_SVH
`define SCML_MAP_SVH

// ***********************************************************************
// Register offsets (one per channel plus status and strap, byte addresses)
// ***********************************************************************
`define SCML_OFS_CH0 8'h00
`define SCML_OFS_CH1 8'h04
`define SCML_OFS_CH2 8'h08
`define SCML_OFS_CH3 8'h0C
`define SCML_OFS_STAT 8'h10
`define SCML_OFS_STRAP 8'h14

// ***********************************************************************
// Field positions inside a channel word
// ***********************************************************************
`define SCML_B_DEC_VAR 0
`define SCML_B_DEC_EN 1
`define SCML_B_CK_SRC 2
`define SCML_B_CK_HALF 3
`define SCML_B_PRI_LO 4
`define SCML_B_PRI_HI 5
`define SCML_B_SEC_LO 6
`define SCML_B_SEC_HI 7
`define SCML_B_ENC_EN 8
`define SCML_CH_BITS 9

// ***********************************************************************
// Reset values
// ***********************************************************************
`define SCML_RST_CH 9'h1AF
`define SCML_RST_THR 2'h2

// ***********************************************************************
// Timing counts
// ***********************************************************************
`define SCML_CLK_NS 40
`define SCML_RD_LAT 1

`endif

// ### design/scml_pkg.sv
/*
  Types shared by the mode latch bank.
  Assumes the map header sits in the include path.
*/
package scml_pkg;
  // Detector threshold code
  typedef enum logic [1:0] {
    SCML_THR_OFF = 2'h0,
    SCML_THR_LOW = 2'h1,
    SCML_THR_MID = 2'h2,
    SCML_THR_HIGH = 2'h3
  } scml_thr_e;

  // Output clock scheme seen by the host
  typedef enum logic [1:0] {
    SCML_CK_REC_FULL = 2'h0,
    SCML_CK_REC_HALF = 2'h1,
    SCML_CK_REF_FULL = 2'h2,
    SCML_CK_REF_HALF = 2'h3
  } scml_ck_e;
endpackage

// ### design/scml_latch_mem.sv
/*
  Small latch store: one word per channel, written by index, read data
  come out of a register one cycle after the read.
  Assumes a single clock and a synchronous active-low reset.
*/
`include "scml_map.svh"

module scml_latch_mem #(
  parameter int NCH = 4,
  parameter int W = `SCML_CH_BITS
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic we_i,
  input wire logic [1:0] widx_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic [1:0] ridx_i,
  output logic [W-1:0] rdata_o,
  output logic [NCH*W-1:0] all_o
);
  logic [W-1:0] word [NCH];

  // Two index bits reach four words at most
  if (NCH < 1 || NCH > 4) begin : g_nch_check
    $error("scml_latch_mem serves one to four words");
  end

  // ***********************************************************************
  // Storage, one process so the array has a single writer
  // ***********************************************************************
  // Each channel keeps its own copy; a write touches one word only
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < NCH; c++) begin
      if (!rstn_i) begin
        word[c] <= W'(`SCML_RST_CH);
      end else if (we_i && widx_i == 2'(c)) begin
        word[c] <= wdata_i;
      end
    end
  end

  // Flat view of every word, one generate slice per channel
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    assign all_o[c*W +: W] = word[c];
  end

  // Registered read port
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= word[ridx_i];
    end
  end
endmodule

// ### verification/scml_host_rx.sv
/*
  Host receive model: rebuilds one channel's output clock pair from the
  character clock and counts the data words that it captures.
  Assumes the character clock is clk_i and the half flag is steady.
*/
module scml_host_rx (
  input wire logic clk_i,
  input wire logic half_i,
  output logic [7:0] words_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic div_q = 1'b0;
  logic [7:0] cap_p = 8'h00;
  logic [7:0] cap_n = 8'h00;
  logic rx_p;
  logic rx_n;
  // ***************************************************************
  // Output clock pair
  // ***************************************************************
  // Half rate toggles once per character, full rate follows it
  always @(posedge clk_i) div_q <= ~div_q;
  assign rx_p = half_i ? div_q : clk_i;
  assign rx_n = ~rx_p;
  // ***************************************************************
  // Capture
  // ***************************************************************
  // Two counters, so no variable has two writers
  always @(posedge rx_p) cap_p <= cap_p + 8'h01;
  always @(posedge rx_n) if (half_i) cap_n <= cap_n + 8'h01;
  assign words_o = cap_p + cap_n;
endmodule

// ### verification/scml_mode_latches_tb.sv
/*
  Self-checking bench of the mode latch bank: register tasks, field
  outputs, clock scheme decode and a host capture model.
  Assumes the design answers reads one cycle after the strobe.
*/
module scml_mode_latches_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i;
  logic rstn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [3:0] ref_half_rate_i = 4'h0;
  logic [31:0] rdata_o;
  logic [3:0] var_o, den_o, src_o, rate_o, enc_o, col_o, ref_o, half_o, pon_o, son_o;
  logic [7:0] pthr_o, sthr_o, words;
  int err_total = 0;
  int checks = 0;
  logic [31:0] w;

  scml_mode_latches dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .ref_half_rate_i(ref_half_rate_i),
    .rdata_o(rdata_o), .rx_decode_variant_sel_o(var_o), .rx_decoder_enable_o(den_o),
    .rx_out_clock_source_sel_o(src_o), .rx_out_clock_half_rate_sel_o(rate_o),
    .primary_detect_threshold_sel_o(pthr_o), .secondary_detect_threshold_sel_o(sthr_o),
    .tx_encoder_enable_o(enc_o), .rx_special_col_o(col_o), .rx_clk_from_ref_o(ref_o),
    .rx_clk_half_o(half_o), .primary_detect_on_o(pon_o), .secondary_detect_on_o(son_o));

  scml_host_rx host (.clk_i(clk_i), .half_i(half_o[0]), .words_o(words));

  // 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ***************************************************************
  // Tasks
  // ***************************************************************
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Outputs settle one edge after the write edge; the task waits two
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk("rdata", rdata_o, exp);
  endtask

  // Host words counted over eight characters
  task automatic host_chk();
    logic [7:0] n0;
    n0 = words;
    repeat (8) @(posedge clk_i);
    #1;
    chk("host words", 8'(words - n0), 8);
  endtask

  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    stop_test();
  end

  // ***************************************************************
  // Sequence
  // ***************************************************************
  initial begin
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    #1;
    chk("reset fields", {var_o, den_o, src_o, rate_o, enc_o}, 20'hFFFFF);
    chk("reset thr", {pthr_o, sthr_o}, 16'hAAAA);
    for (int c = 0; c < 4; c++) rd(8'(4 * c), 32'h1AF);
    host_chk();
    // Channel 0 cleared, others untouched
    wr(8'h00, 32'h0);
    chk("ch0 cleared", {var_o, den_o, rate_o, enc_o, pon_o}, 20'hEEEEE);
    chk("ch0 col", col_o, 4'hE);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h1AF);
    chk("rdata idle", rdata_o, 32'h1AF);
    @(posedge clk_i);
    #1;
    chk("rdata drop", rdata_o, 32'h0);
    host_chk();
    // Clock scheme for every source, rate and strap on channel 2
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i) ref_half_rate_i <= {1'b0, i[2], 2'b00};
      wr(8'h08, 32'h1A3 | (i[0] << 2) | (i[1] << 3));
      chk("from ref", ref_o[2], i[0]);
      chk("source", src_o[2], i[0]);
      chk("half", half_o[2], i[1] | (i[0] & i[2]));
      rd(8'h10, {16'h0000, 4'hE, 4'hE, 2'h3, i[0], i[1] | (i[0] & i[2]), 4'hC});
    end
    // Decode variant against decoder enable
    for (int j = 0; j < 4; j++) begin
      wr(8'h0C, 32'h1AC | j);
      chk("variant", {den_o[3], var_o[3]}, j);
      chk("column", col_o[3], j[0] & j[1]);
    end
    // Every detector threshold code on channel 3
    for (int k = 0; k < 4; k++) begin
      wr(8'h0C, 32'h10F | (k << 4) | (k << 6));
      chk("thr", {pthr_o[7:6], sthr_o[7:6]}, (k << 2) | k);
      chk("det on", {pon_o[3], son_o[3]}, (k != 0) ? 2'h3 : 2'h0);
    end
    wr(8'h04, 32'h0AF);
    chk("encoder", enc_o, 4'hC);
    rd(8'h04, 32'h0AF);
    // Unmapped and unaligned places
    w = {den_o, var_o, enc_o};
    wr(8'h18, 32'h0);
    wr(8'h05, 32'h0);
    chk("ignored", {den_o, var_o, enc_o}, w);
    rd(8'h18, 32'h0);
    rd(8'h06, 32'h0);
    // Second reset in mid-run
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    #1;
    chk("rereset", {var_o, den_o, enc_o, pthr_o}, 20'hFFFAA);
    rd(8'h08, 32'h1AF);
    stop_test();
  end
endmodule
